// >>> rtl/disk_data_ctrl_seq.sv
// Purpose: disk sequencer flags, sector counters, dma completion and
//          interrupt line of a disk data controller
// Assumes: all event inputs are one-cycle pulses on REF_CLK
// Notes:   REF_CLK is the disk read clock; 16 cycles = 16 read clocks
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - local dma done clears local busy, also remote busy if tracking
// - header-check completes after header; data ECC error only
// - header CRC/ECC error sets header fault, no interrupt or stop
// - header fault clears only on error-free header of sought sector
// - read-header header error: interrupt, stop, both flags, error zero
// - sector ops write loads disk and dma copies; read shows disk copy
// - disk copy drops at header match; dma copy at last data byte
// - threshold loads burst counter; reload only at terminal count, reset
// - multisector is one long transfer; short last burst still moves
// - burst counter keeps the short remainder value afterwards
// - read clock glitch knocks sequencer out; needs reset and re-enable
// - dma side alone drives completion interrupts and clears busy flags
// - remote completion is raised only while disk sequencer not frozen
// - sequencer also freezes awaiting data sync and next header sync
// - interrupt release waits for freeze to end despite status reads
// - ack sampled at t4; no toggling per request needed
// - first request edge is not synchronous to the bus clock
// - status read releases interrupt, not within 16 read clocks
module disk_data_ctrl_seq
  import dsk_seq_pkg::*;
#(
  parameter int SECTOR_BYTES = 512,
  parameter int HEADER_BYTES = 4
)
(
  input  wire logic             REF_CLK,
  input  wire logic             RSTN,
  input  wire logic             CMD_LOAD,
  input  wire logic [1:0]       CMD_CODE,
  input  wire logic             TRACKING,
  input  wire logic             REENABLE,
  input  wire logic             RCLK_GLITCH,
  input  wire logic             HDR_SYNC,
  input  wire logic             HDR_END,
  input  wire logic             HDR_CRC_ERR,
  input  wire logic             HDR_TARGET,
  input  wire logic             DATA_SYNC,
  input  wire logic             DATA_END,
  input  wire logic             DATA_ECC_ERR,
  input  wire logic             SECTOR_OPS_WR,
  input  wire logic [CNT_W-1:0] SECTOR_OPS_DATA,
  input  wire logic             LBT_WR,
  input  wire logic             RBT_WR,
  input  wire logic [BST_W-1:0] THR_DATA,
  input  wire logic             REMOTE_START,
  input  wire logic [LEN_W-1:0] REMOTE_LEN,
  input  wire logic             LOCAL_ACK,
  input  wire logic             REMOTE_ACK,
  input  wire logic             STATUS_RD,
  output logic                  LOCAL_REQ,
  output logic                  REMOTE_REQ,
  output logic                  READ_GATE,
  output logic                  READY,
  output logic                  LOCAL_BUSY,
  output logic                  REMOTE_BUSY,
  output logic                  HDR_FAULT,
  output logic                  ERR_DETECTED,
  output logic                  HDR_MATCH_DONE,
  output logic                  OP_COMPLETE,
  output logic                  REMOTE_DONE,
  output logic [7:0]            ERROR_REG,
  output logic [CNT_W-1:0]      SECTOR_OPS_COUNT,
  output logic                  INT_N
);
  // refuse lengths the byte counters cannot hold
  if (SECTOR_BYTES < 1 || SECTOR_BYTES >= 2**16) begin : g_sec_chk
    $error("SECTOR_BYTES out of range");
  end
  if (HEADER_BYTES < 1 || HEADER_BYTES > SECTOR_BYTES) begin : g_hdr_chk
    $error("HEADER_BYTES out of range");
  end

  localparam logic [LEN_W-1:0] SEC_LEN = LEN_W'(SECTOR_BYTES);
  localparam logic [LEN_W-1:0] HDR_LEN = LEN_W'(HEADER_BYTES);
  localparam logic [4:0] HOLD = 5'(INT_HOLD_RCLKS);

  typedef enum logic [2:0] {
    ST_OFF, ST_STANDBY, ST_HDR_WAIT, ST_HDR, ST_DATA_WAIT, ST_DATA
  } dsk_st_t;

  dsk_st_t          st, next_st;
  cmd_t             cmd, next_cmd;
  logic             glitched, next_glitched;
  logic [CNT_W-1:0] disk_ops, next_disk_ops;
  logic [CNT_W-1:0] dma_ops, next_dma_ops;
  logic [LEN_W-1:0] sec_byte, next_sec_byte;
  logic [LEN_W-1:0] unit_len, sec_len;
  logic             lbusy, next_lbusy;
  logic             rbusy, next_rbusy;
  logic             hfault, next_hfault;
  logic             err_det, next_err_det;
  logic             err_ecc, next_err_ecc;
  logic             header_match_complete_flag, next_hmc;
  logic             op_done, next_op_done;
  logic             rem_done, next_rem_done;
  logic             rem_pend, next_rem_pend;
  logic             op_evt, err_evt, rem_evt, lstart, rstart;
  logic             int_line, next_int_line;
  logic             clr_pend, next_clr_pend;
  logic [4:0]       age, next_age;
  logic             frozen, clr_apply;

  dma_ch_if lch ();
  dma_ch_if rch ();

  ////////////////////////////////////////////////////////////////////
  // the waits for a sync match stop the disk-side clock
  assign frozen = (st == ST_HDR_WAIT) || (st == ST_DATA_WAIT);
  // a pending release is applied on the disk-side clock only
  assign clr_apply = clr_pend && !frozen;

  // header commands move only header bytes per sector
  assign unit_len = (cmd_t'(CMD_CODE) == CMD_RD_HDR ||
                     cmd_t'(CMD_CODE) == CMD_RD_HDR_CHK) ? HDR_LEN : SEC_LEN;
  assign sec_len = (cmd == CMD_RD_HDR || cmd == CMD_RD_HDR_CHK)
                   ? HDR_LEN : SEC_LEN;

  assign lch.start = lstart;
  assign lch.total = unit_len * LEN_W'(disk_ops);
  assign lch.thresh = THR_DATA;
  assign lch.thr_wr = LBT_WR;
  assign rch.start = rstart;
  assign rch.total = REMOTE_LEN;
  assign rch.thresh = THR_DATA;
  assign rch.thr_wr = RBT_WR;

  dma_burst_engine u_local (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .ch    (lch.eng),
    .ack   (LOCAL_ACK),
    .req   (LOCAL_REQ)
  );

  dma_burst_engine u_remote (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .ch    (rch.eng),
    .ack   (REMOTE_ACK),
    .req   (REMOTE_REQ)
  );

  ////////////////////////////////////////////////////////////////////
  // disk sequencer, dma side counters and status flags
  always_comb begin
    next_st = st;
    next_cmd = cmd;
    next_glitched = glitched;
    next_disk_ops = disk_ops;
    next_dma_ops = dma_ops;
    next_sec_byte = sec_byte;
    next_lbusy = lbusy;
    next_rbusy = rbusy;
    next_hfault = hfault;
    next_err_det = err_det;
    next_err_ecc = err_ecc;
    next_hmc = header_match_complete_flag;
    next_op_done = op_done;
    next_rem_done = rem_done;
    next_rem_pend = rem_pend;
    op_evt = 1'b0;
    err_evt = 1'b0;
    rem_evt = 1'b0;
    lstart = 1'b0;
    rstart = 1'b0;
    // released flags clear first so a same-cycle set below wins
    if (clr_apply) begin
      next_hmc = 1'b0;
      next_op_done = 1'b0;
      next_rem_done = 1'b0;
    end
    case (st)
      ST_OFF: begin
        // a glitched sequencer stays out until reset then re-enable
        if (REENABLE && !glitched) begin
          next_st = ST_STANDBY;
        end
      end
      ST_STANDBY: begin
        if (CMD_LOAD) begin
          next_st = ST_HDR_WAIT;
          next_cmd = cmd_t'(CMD_CODE);
          next_lbusy = 1'b1;
          next_err_det = 1'b0;
          next_err_ecc = 1'b0;
          lstart = 1'b1;
        end
      end
      ST_HDR_WAIT: begin
        if (HDR_SYNC) begin
          next_st = ST_HDR;
        end
      end
      ST_HDR: begin
        if (HDR_END) begin
          next_st = ST_HDR_WAIT;
          if (HDR_CRC_ERR) begin
            next_hfault = 1'b1;
            if (cmd == CMD_RD_HDR) begin
              next_err_det = 1'b1;
              err_evt = 1'b1;
              next_st = ST_STANDBY;
            end
          end else if (HDR_TARGET) begin
            next_hfault = 1'b0;
            next_hmc = 1'b1;
            if (disk_ops != '0) begin
              next_disk_ops = disk_ops - CNT_W'(1);
            end
            if (cmd != CMD_RD_HDR) begin
              next_st = ST_DATA_WAIT;
            end else if (disk_ops <= CNT_W'(1)) begin
              next_st = ST_STANDBY;
            end
          end
        end
      end
      ST_DATA_WAIT: begin
        if (DATA_SYNC) begin
          next_st = ST_DATA;
        end
      end
      ST_DATA: begin
        if (DATA_END) begin
          // header-check ends silently here unless the check fails
          if (DATA_ECC_ERR) begin
            next_err_det = 1'b1;
            next_err_ecc = 1'b1;
            err_evt = 1'b1;
            next_st = ST_STANDBY;
          end else if (disk_ops == '0) begin
            next_st = ST_STANDBY;
          end else begin
            next_st = ST_HDR_WAIT;
          end
        end
      end
      default: next_st = ST_OFF;
    endcase
    if (RCLK_GLITCH) begin
      next_st = ST_OFF;
      next_glitched = 1'b1;
    end
    // dma side: counts bytes per sector, blind to disk errors
    if (lch.moved) begin
      if (sec_byte == sec_len - LEN_W'(1)) begin
        next_sec_byte = '0;
        if (dma_ops != '0) begin
          next_dma_ops = dma_ops - CNT_W'(1);
        end
      end else begin
        next_sec_byte = sec_byte + LEN_W'(1);
      end
    end
    if (lstart) begin
      next_sec_byte = '0;
    end
    if (lch.done) begin
      next_lbusy = 1'b0;
      next_op_done = 1'b1;
      op_evt = 1'b1;
      if (TRACKING) begin
        next_rbusy = 1'b0;
      end
    end
    if (REMOTE_START && !rbusy) begin
      next_rbusy = 1'b1;
      rstart = 1'b1;
    end
    // remote completion waits here while the disk clock is stopped
    if (rch.done) begin
      next_rbusy = 1'b0;
      next_rem_pend = 1'b1;
    end else if (rem_pend && !frozen) begin
      next_rem_pend = 1'b0;
      next_rem_done = 1'b1;
      rem_evt = 1'b1;
    end
    // a write loads both copies and beats any decrement
    if (SECTOR_OPS_WR) begin
      next_disk_ops = SECTOR_OPS_DATA;
      next_dma_ops = SECTOR_OPS_DATA;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st <= ST_OFF;
      cmd <= CMD_RD_DATA;
      glitched <= 1'b0;
      disk_ops <= OPS_RST;
      dma_ops <= OPS_RST;
      sec_byte <= '0;
      lbusy <= 1'b0;
      rbusy <= 1'b0;
      hfault <= 1'b0;
      err_det <= 1'b0;
      err_ecc <= 1'b0;
      header_match_complete_flag <= 1'b0;
      op_done <= 1'b0;
      rem_done <= 1'b0;
      rem_pend <= 1'b0;
    end else begin
      st <= next_st;
      cmd <= next_cmd;
      glitched <= next_glitched;
      disk_ops <= next_disk_ops;
      dma_ops <= next_dma_ops;
      sec_byte <= next_sec_byte;
      lbusy <= next_lbusy;
      rbusy <= next_rbusy;
      hfault <= next_hfault;
      err_det <= next_err_det;
      err_ecc <= next_err_ecc;
      header_match_complete_flag <= next_hmc;
      op_done <= next_op_done;
      rem_done <= next_rem_done;
      rem_pend <= next_rem_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt line: a read within the hold window is not a release
  always_comb begin
    next_int_line = int_line;
    next_clr_pend = clr_pend;
    next_age = (age == HOLD) ? age : age + 5'(1);
    if (STATUS_RD && int_line && age == HOLD) begin
      next_clr_pend = 1'b1;
    end
    if (clr_apply) begin
      next_clr_pend = 1'b0;
      next_int_line = 1'b0;
    end
    // a new cause always wins over a release
    if (op_evt || err_evt || rem_evt) begin
      next_int_line = 1'b1;
      next_clr_pend = 1'b0;
      next_age = '0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      int_line <= 1'b0;
      clr_pend <= 1'b0;
      age <= HOLD;
    end else begin
      int_line <= next_int_line;
      clr_pend <= next_clr_pend;
      age <= next_age;
    end
  end

  // outputs from flops, READ_GATE and READY through a state decode
  assign READ_GATE = (st != ST_OFF) && (st != ST_STANDBY);
  assign READY = (st == ST_STANDBY);
  assign LOCAL_BUSY = lbusy;
  assign REMOTE_BUSY = rbusy;
  assign HDR_FAULT = hfault;
  assign ERR_DETECTED = err_det;
  assign HDR_MATCH_DONE = header_match_complete_flag;
  assign OP_COMPLETE = op_done;
  assign REMOTE_DONE = rem_done;
  assign ERROR_REG = ERR_RST | (8'(err_ecc) << ERR_ECC_BIT);
  assign SECTOR_OPS_COUNT = disk_ops;
  assign INT_N = !int_line;

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RSTN);

  sequence hdr_bad;
    st == ST_HDR && HDR_END && HDR_CRC_ERR;
  endsequence

  hdr_fault_a: assert property (
    hdr_bad and (cmd != CMD_RD_HDR && !RCLK_GLITCH && !op_evt && !rem_evt)
    |=> HDR_FAULT && st == ST_HDR_WAIT && !$rose(int_line))
    else $error("header error not passive");
  hdr_clear_a: assert property (
    st == ST_HDR && HDR_END && !HDR_CRC_ERR && !HDR_TARGET && HDR_FAULT
    |=> HDR_FAULT)
    else $error("header fault cleared by wrong header");
  rdhdr_term_a: assert property (
    hdr_bad and (cmd == CMD_RD_HDR && !RCLK_GLITCH)
    |=> ERR_DETECTED && HDR_FAULT && ERROR_REG == 8'h00 && READY
    ##1 !INT_N)
    else $error("read header error not terminated");
  ops_load_a: assert property (
    SECTOR_OPS_WR |=> SECTOR_OPS_COUNT == $past(SECTOR_OPS_DATA))
    else $error("sector ops write not loaded");
  disk_dec_a: assert property (
    st == ST_HDR && HDR_END && !HDR_CRC_ERR && HDR_TARGET &&
    !SECTOR_OPS_WR && disk_ops != '0
    |=> SECTOR_OPS_COUNT == $past(disk_ops) - CNT_W'(1))
    else $error("disk side count not decremented");
  local_done_a: assert property (
    lch.done && !CMD_LOAD |=> !LOCAL_BUSY && OP_COMPLETE
    ##1 !INT_N)
    else $error("local completion missing");
  glitch_out_a: assert property (
    RCLK_GLITCH |=> st == ST_OFF ##1 st == ST_OFF)
    else $error("glitch did not stop sequencer");
  freeze_defer_a: assert property (
    rem_pend && frozen |=> rem_pend && !$rose(REMOTE_DONE))
    else $error("remote completion raised while frozen");
  freeze_hold_a: assert property (
    int_line && frozen |=> int_line)
    else $error("interrupt released during freeze");
  int_hold_a: assert property (
    $rose(int_line) |-> int_line [*8] ##1 int_line [*8])
    else $error("interrupt released within hold window");
endmodule
`default_nettype wire

// >>> rtl/dsk_seq_pkg.sv
// Purpose: shared constants for the disk sequencer and its dma engines
// Assumes: one clock, the disk read clock
// Notes:   widths and reset values live here only
package dsk_seq_pkg;
  localparam int LEN_W = 24;
  localparam int CNT_W = 8;
  localparam int BST_W = 8;
  localparam int INT_HOLD_RCLKS = 16;
  localparam int ERR_ECC_BIT = 0;
  localparam logic [CNT_W-1:0] OPS_RST = 8'h00;
  localparam logic [BST_W-1:0] BST_RST = 8'h01;
  localparam logic [7:0] ERR_RST = 8'h00;
  // command codes on the command port, in this order
  typedef enum logic [1:0] {
    CMD_RD_DATA,
    CMD_RD_HDR,
    CMD_RD_HDR_CHK,
    CMD_WR_DATA
  } cmd_t;
endpackage

// >>> rtl/dma_ch_if.sv
// Purpose: link between the sequencer and one dma engine
// Assumes: same clock on both sides
// Notes:   strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface dma_ch_if;
  import dsk_seq_pkg::*;
  logic             start;
  logic [LEN_W-1:0] total;
  logic [BST_W-1:0] thresh;
  logic             thr_wr;
  logic             moved;
  logic             done;
  logic             busy;
  modport ctl (output start, total, thresh, thr_wr,
               input moved, done, busy);
  modport eng (input start, total, thresh, thr_wr,
               output moved, done, busy);
endinterface
`default_nettype wire

// >>> rtl/dma_burst_engine.sv
// Purpose: one dma channel: bus cycles t1..t4 and burst counting
// Assumes: ack is synchronous to clk
// Notes:   burst counter is not reloaded at end of a transfer unless it is at terminal count
`timescale 1ns/1ps
`default_nettype none
module dma_burst_engine
  import dsk_seq_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  dma_ch_if.eng     ch,
  input  wire logic ack,
  output logic      req
);
  typedef enum logic [2:0] {S_IDLE, S_T1, S_T2, S_T3, S_T4} bus_st_t;
  bus_st_t          st, next_st;
  logic [LEN_W-1:0] remain, next_remain;
  logic [BST_W-1:0] burst, next_burst;
  logic [BST_W-1:0] thr, next_thr;
  logic             gap, next_gap;

  // request is combinational from state, so its first edge is not
  // aligned to any bus clock; the bus side must synchronise it
  assign req = (remain != '0) && !gap;
  assign ch.moved = (st == S_T4) && ack;
  assign ch.done = ch.moved && (remain == LEN_W'(1));
  assign ch.busy = (remain != '0);

  // next state: bus cycle, byte and burst counting
  always_comb begin
    next_st = st;
    next_remain = remain;
    next_burst = burst;
    next_thr = thr;
    next_gap = 1'b0;
    if (ch.start) begin
      next_remain = ch.total;
    end
    case (st)
      S_IDLE: begin
        if (req && ack) begin
          next_st = S_T1;
        end
      end
      S_T1: next_st = S_T2;
      S_T2: next_st = S_T3;
      S_T3: next_st = S_T4;
      S_T4: begin
        next_st = S_IDLE;
        // ack is looked at here and in S_IDLE; held high it keeps bursting
        if (ack) begin
          next_remain = remain - LEN_W'(1);
          if (burst <= BST_W'(1)) begin
            next_burst = thr;
            next_gap = 1'b1;
          end else begin
            next_burst = burst - BST_W'(1);
          end
        end
      end
      default: next_st = S_IDLE;
    endcase
    // programming the threshold copies it into the burst counter
    if (ch.thr_wr) begin
      next_thr = ch.thresh;
      next_burst = ch.thresh;
    end
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= S_IDLE;
      remain <= '0;
      burst <= BST_RST;
      thr <= BST_RST;
      gap <= 1'b0;
    end else begin
      st <= next_st;
      remain <= next_remain;
      burst <= next_burst;
      thr <= next_thr;
      gap <= next_gap;
    end
  end

  ////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence bus_cycle;
    st == S_T1 ##1 st == S_T2 ##1 st == S_T3 ##1 st == S_T4;
  endsequence

  cycle_order_a: assert property (
    st == S_IDLE && req && ack |=> bus_cycle)
    else $error("bus cycle did not run t1 to t4");
  ack_sample_a: assert property (
    st == S_T4 && !ack && !ch.start |=> remain == $past(remain))
    else $error("byte counted without ack at t4");
  burst_reload_a: assert property (
    ch.moved && burst <= BST_W'(1) && !ch.thr_wr
    |=> burst == thr && !req)
    else $error("burst counter not reloaded at terminal count");
  short_keep_a: assert property (
    ch.done && burst > BST_W'(1) && !ch.thr_wr && !ch.start
    |=> burst == $past(burst) - BST_W'(1) && remain == '0)
    else $error("short final burst value not kept");
endmodule
`default_nettype wire

// >>> testbench/dma_ack_model.sv
// Purpose: bus arbitration partner that grants one dma channel
// Assumes: request and grant share the disk read clock
// Notes:   slow mode drops the grant every other cycle
`timescale 1ns/1ps
`default_nettype none
module dma_ack_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic req,
  input  wire logic slow,
  output logic      ack
);
  ////////////////////////////////////////////////////////////////////////////
  logic next_ack;

  // grant registers the request first, since its rising edge is not timed
  // to our clock; the grant may stay up for a whole burst
  always_comb begin
    next_ack = req && !(slow && ack);
  end

  // grant register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end
endmodule
`default_nettype wire

// >>> testbench/disk_data_ctrl_seq_bench.sv
// Purpose: self-checking bench for the disk sequencer block
// Assumes: one clock; both dma channels granted by partner models
// Notes:   burst counts are predicted by a small integer model
`timescale 1ns/1ps
`default_nettype none
module disk_data_ctrl_seq_bench
  import dsk_seq_pkg::*;
;
  localparam int LD = 0, RE = 1, GL = 2, HS = 3, HE = 4, DS = 5;
  localparam int DE = 6, OW = 7, LW = 8, RS = 10, SR = 11;
  logic             ref_clk = 1'b0, rstn = 1'b0, herr = 1'b0;
  logic             ecc = 1'b0, lslow = 1'b0, lq = 1'b0, lack, rack;
  logic             trk = 1'b0, tgt = 1'b1;
  logic [11:0]      ev = '0;
  logic [1:0]       code = '0;
  logic [7:0]       ops = '0, thd = '0, erreg, cnt;
  logic [LEN_W-1:0] rlen = '0;
  logic             lreq, rreq, rgate, ready, lbusy, rbusy, hf, ed, hmd;
  logic             opc, rdone, int_n;
  int               fails = 0, comparisons = 0, nb = 0, bc = 1, thr = 1;

  disk_data_ctrl_seq #(.SECTOR_BYTES(8), .HEADER_BYTES(2)) dut (
    .REF_CLK(ref_clk), .RSTN(rstn), .CMD_LOAD(ev[LD]), .CMD_CODE(code),
    .TRACKING(trk), .REENABLE(ev[RE]), .RCLK_GLITCH(ev[GL]),
    .HDR_SYNC(ev[HS]), .HDR_END(ev[HE]), .HDR_CRC_ERR(herr),
    .HDR_TARGET(tgt), .DATA_SYNC(ev[DS]), .DATA_END(ev[DE]),
    .DATA_ECC_ERR(ecc), .SECTOR_OPS_WR(ev[OW]), .SECTOR_OPS_DATA(ops),
    .LBT_WR(ev[LW]), .RBT_WR(ev[9]), .THR_DATA(thd),
    .REMOTE_START(ev[RS]), .REMOTE_LEN(rlen), .LOCAL_ACK(lack),
    .REMOTE_ACK(rack), .STATUS_RD(ev[SR]), .LOCAL_REQ(lreq),
    .REMOTE_REQ(rreq), .READ_GATE(rgate), .READY(ready),
    .LOCAL_BUSY(lbusy), .REMOTE_BUSY(rbusy), .HDR_FAULT(hf),
    .ERR_DETECTED(ed), .HDR_MATCH_DONE(hmd), .OP_COMPLETE(opc),
    .REMOTE_DONE(rdone), .ERROR_REG(erreg), .SECTOR_OPS_COUNT(cnt),
    .INT_N(int_n));
  dma_ack_model lp (.clk(ref_clk), .rst_n(rstn), .req(lreq),
    .slow(lslow), .ack(lack));
  dma_ack_model rp (.clk(ref_clk), .rst_n(rstn), .req(rreq),
    .slow(1'b0), .ack(rack));

  ////////////////////////////////////////////////////////////////////////////
  // clock, and a count of local request drops, one per burst
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    lq <= lreq;
    if (lq && !lreq) nb <= nb + 1;
  end

  // burst counter model: reloads only at terminal count, so a short last
  // burst leaves a small value for the next transfer
  function automatic int bursts(int t);
    int n, b;
    n = 0;
    while (t > 0) begin
      b = (bc < t) ? bc : t;
      t -= b;
      bc = (b == bc) ? thr : bc - b;
      n++;
    end
    return n;
  endfunction

  task automatic w(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // one-cycle strobe on event line i
  task automatic p(int i);
    @(posedge ref_clk) ev <= 12'h001 << i;
    @(posedge ref_clk) ev <= '0;
    #1;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", n, e, s);
    end
  endtask
  // bounded wait for the local channel to finish
  task automatic wait_idle;
    for (int i = 0; i < 400 && lbusy; i++) w(1);
    chk("lbusy", 8'h00, 8'(lbusy));
  endtask
  task automatic sect;
    p(HS);
    p(HE);
    p(DS);
    p(DE);
  endtask
  task automatic rst_en;
    rstn <= 1'b0;
    w(2);
    rstn <= 1'b1;
    p(RE);
    w(1);
    bc = 1;
    thr = 1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // the whole run is under a thousand cycles; this cuts a hang short
  initial begin
    #200000;
    fails++;
    tally_and_finish;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h8efe_966c));
    w(20);
    rstn <= 1'b1;
    w(2);
    chk("ready", 8'h00, 8'(ready));
    chk("int_n", 8'h01, 8'(int_n));
    p(RE);
    w(1);
    chk("ready", 8'h01, 8'(ready));
    // one sector, threshold above the transfer length
    thd <= 8'h10;
    ops <= 8'h01;
    p(LW);
    thr = 16;
    bc = 16;
    p(OW);
    chk("count", 8'h01, cnt);
    code <= CMD_RD_DATA;
    nb = 0;
    p(LD);
    wait_idle;
    w(2);
    chk("bursts", 8'(bursts(8)), 8'(nb));
    chk("op_done", 8'h01, 8'(opc));
    chk("int_n", 8'h00, 8'(int_n));
    // remote finishes while the sequencer waits for a header
    rlen <= 24'(1 + $urandom % 4);
    p(RS);
    w(60);
    chk("rdone", 8'h00, 8'(rdone));
    herr <= 1'b1;
    p(HS);
    w(2);
    chk("rdone", 8'h01, 8'(rdone));
    p(HE);
    chk("hfault", 8'h01, 8'(hf));
    chk("rgate", 8'h01, 8'(rgate));
    herr <= 1'b0;
    p(HS);
    p(HE);
    chk("hfault", 8'h00, 8'(hf));
    chk("hmatch", 8'h01, 8'(hmd));
    w(100);
    chk("count", 8'h00, cnt);
    p(SR);
    w(3);
    chk("int_n", 8'h00, 8'(int_n));
    p(DS);
    w(3);
    chk("int_n", 8'h01, 8'(int_n));
    p(DE);
    chk("ready", 8'h01, 8'(ready));
    // two sectors start from the leftover burst count
    ops <= 8'h02;
    p(OW);
    nb = 0;
    lslow <= 1'($urandom % 2);
    p(LD);
    wait_idle;
    w(2);
    chk("bursts", 8'(bursts(16)), 8'(nb));
    sect;
    chk("count", 8'h01, cnt);
    sect;
    chk("ready", 8'h01, 8'(ready));
    // read header with a bad header
    rst_en;
    ops <= 8'h01;
    p(OW);
    code <= CMD_RD_HDR;
    p(LD);
    wait_idle;
    herr <= 1'b1;
    p(HS);
    p(HE);
    chk("err_det", 8'h01, 8'(ed));
    chk("hfault", 8'h01, 8'(hf));
    chk("err_reg", 8'h00, erreg);
    chk("ready", 8'h01, 8'(ready));
    p(SR);
    w(2);
    chk("int_n", 8'h00, 8'(int_n));
    w(14);
    p(SR);
    w(3);
    chk("int_n", 8'h01, 8'(int_n));
    // header check then a data field with an ecc error
    rst_en;
    herr <= 1'b0;
    p(OW);
    code <= CMD_RD_HDR_CHK;
    p(LD);
    p(HS);
    p(HE);
    wait_idle;
    chk("op_done", 8'h01, 8'(opc));
    ecc <= 1'b1;
    p(DS);
    p(DE);
    chk("err_reg", 8'h01, erreg);
    chk("err_det", 8'h01, 8'(ed));
    // tracking: local done frees the remote channel too; a foreign header
    // leaves the fault alone; a stuck read gate needs outside help
    rst_en;
    trk <= 1'b1;
    ecc <= 1'b0;
    code <= CMD_RD_DATA;
    thd <= 8'h04;
    rlen <= 24'h00_0100;
    p(9);
    p(RS);
    chk("rbusy", 8'h01, 8'(rbusy));
    chk("rreq", 8'h01, 8'(rreq));
    p(OW);
    p(LD);
    herr <= 1'b1;
    p(HS);
    p(HE);
    herr <= 1'b0;
    tgt <= 1'b0;
    p(HS);
    p(HE);
    chk("hfault", 8'h01, 8'(hf));
    wait_idle;
    chk("rbusy", 8'h00, 8'(rbusy));
    w(50);
    chk("rgate", 8'h01, 8'(rgate));
    rst_en;
    chk("rgate", 8'h00, 8'(rgate));
    trk <= 1'b0;
    tgt <= 1'b1;
    // clock glitch needs reset before re-enable works
    p(GL);
    w(1);
    chk("ready", 8'h00, 8'(ready));
    p(RE);
    w(1);
    chk("ready", 8'h00, 8'(ready));
    rst_en;
    chk("ready", 8'h01, 8'(ready));
    tally_and_finish;
  end
endmodule
`default_nettype wire
